/* core/pfe_pkg.sv */
/* pfe_pkg: register map, field layout, bus codes and helpers of the
   peripheral flag and enable bank.
   Assumes a 32-bit AXI4-Lite bus, one register per aligned word. */
package pfe_pkg;

  // ****************************************
  // Bus and address layout
  // ****************************************
  localparam int         AW       = 16;
  localparam int         DW       = 32;
  localparam int         IW       = 12;
  localparam int         IDX_LSB  = 2;
  localparam int         BYTE_W   = 8;
  localparam int         STRB_W   = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [IW-1:0] IDX_CORE_EN    = 12'hebd;
  localparam logic [IW-1:0] IDX_CLKADC_EN  = 12'hebe;
  localparam logic [IW-1:0] IDX_VOLTCMP_EN = 12'hebf;
  localparam logic [IW-1:0] IDX_SERIAL_EN  = 12'hec0;
  localparam logic [IW-1:0] IDX_TIMER_EN   = 12'hec1;
  localparam logic [IW-1:0] IDX_GATE_EN    = 12'hec2;
  localparam logic [IW-1:0] IDX_GATE_FLAGS = 12'heca;
  localparam logic [IW-1:0] IDX_CC_FLAGS   = 12'hecb;
  localparam logic [IW-1:0] IDX_SYS_FLAGS  = 12'hecc;
  localparam logic [IW-1:0] IDX_IRQ_STATUS = 12'hed0;
  localparam logic [IW-1:0] IDX_IRQ_MASK   = 12'hed1;

  // ****************************************
  // Enable registers
  // ****************************************
  localparam int NUM_EN = 6;
  localparam int EN_CORE = 0;
  localparam int EN_GATE = 5;
  localparam logic [IW-1:0] EN_IDX [NUM_EN] = '{IDX_CORE_EN,
    IDX_CLKADC_EN, IDX_VOLTCMP_EN, IDX_SERIAL_EN, IDX_TIMER_EN,
    IDX_GATE_EN};
  localparam logic [BYTE_W-1:0] EN_MASK [NUM_EN] = '{8'h37, 8'hc3,
    8'hc3, 8'h33, 8'h3f, 8'h07};
  localparam logic [BYTE_W-1:0] EN_RESET = 8'h00;
  localparam int TIMER0_EN_BIT = 5;
  localparam int PINCHG_EN_BIT = 4;
  localparam int EXT_EN_LSB    = 0;
  localparam int EXT_W         = 3;
  localparam int CORE_W        = EXT_W + 2;

  // ****************************************
  // Flag vector layout
  // ****************************************
  localparam int FL_W        = 9;
  localparam int FL_GATE_LSB = 0;
  localparam int GATE_W      = 3;
  localparam int FL_CC_LSB   = 3;
  localparam int CC_W        = 2;
  localparam int FL_SCAN     = 5;
  localparam int FL_CRC      = 6;
  localparam int FL_NVM      = 7;
  localparam int FL_WAVE     = 8;
  localparam int XEN_W       = FL_W - GATE_W;
  localparam int SYS_SCAN_BIT = 7;
  localparam int SYS_CRC_BIT  = 6;
  localparam int SYS_NVM_BIT  = 5;
  localparam int SYS_WAVE_BIT = 0;
  localparam logic [FL_W-1:0] FL_RESET = 9'h000;

  // ****************************************
  // Modes and states
  // ****************************************
  localparam int CC_MODE_W = 2;
  typedef enum logic [CC_MODE_W-1:0] {
    CC_OFF = 2'h0, CC_CAPTURE = 2'h1, CC_COMPARE = 2'h2, CC_PWM = 2'h3
  } pfe_cc_mode_t;
  typedef enum logic [1:0] {WS_IDLE = 2'h1, WS_RESP = 2'h2} pfe_wstate_t;
  typedef enum logic [1:0] {RS_IDLE = 2'h1, RS_DATA = 2'h2} pfe_rstate_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic cc_hit(input logic [CC_MODE_W-1:0] mode,
                                  input logic cap, input logic cmp);
    cc_hit = (mode == CC_CAPTURE && cap) || (mode == CC_COMPARE && cmp);
  endfunction : cc_hit

  function automatic logic [IW-1:0] addr_idx(input logic [AW-1:0] a);
    addr_idx = a[IDX_LSB +: IW];
  endfunction : addr_idx

  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic [IW-1:0] i;
    i = addr_idx(a);
    is_mapped = (a[AW-1:IDX_LSB+IW] == '0) &&
      ((i >= IDX_CORE_EN && i <= IDX_GATE_EN) ||
       (i >= IDX_GATE_FLAGS && i <= IDX_SYS_FLAGS) ||
       i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK);
  endfunction : is_mapped

endpackage : pfe_pkg

/* core/pfe_sticky_if.sv */
/* pfe_sticky_if: set, write and state lines of one sticky bit bank.
   Assumes owner and bank run on the same clock. */
`timescale 1ns/10ps
interface pfe_sticky_if #(parameter int W = 9);
  logic [W-1:0] set;
  logic [W-1:0] wr_en;
  logic [W-1:0] wr_val;
  logic [W-1:0] q;
  modport owner (output set, output wr_en, output wr_val, input q);
  modport bank  (input set, input wr_en, input wr_val, output q);
endinterface : pfe_sticky_if

/* core/pfe_sticky_bank.sv */
/* pfe_sticky_bank: bank of sticky bits, hardware set, software write.
   Assumes set pulses and writes are synchronous to aclk. */
`timescale 1ns/10ps
module pfe_sticky_bank
  import pfe_pkg::*;
#(
  parameter int W   = FL_W,
  parameter bit W1C = 1'b0
)
(
  input wire logic    aclk,
  input wire logic    aresetn,
  pfe_sticky_if.bank  sb
);

  // Set is ORed last so an event beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sb.q <= W'(FL_RESET);
    end else if (W1C) begin
      sb.q <= sb.set | (sb.q & ~(sb.wr_en & sb.wr_val));
    end else begin
      sb.q <= sb.set | (sb.wr_en & sb.wr_val) |
              (sb.q & ~sb.wr_en);
    end
  end

endmodule : pfe_sticky_bank

/* core/pfe_enable_reg.sv */
/* pfe_enable_reg: one 8-bit enable register with a field mask.
   Assumes the write strobe lasts one cycle. */
`timescale 1ns/10ps
module pfe_enable_reg
  import pfe_pkg::*;
#(
  parameter logic [BYTE_W-1:0] MASK = EN_RESET
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              wr_stb,
  input  wire logic [BYTE_W-1:0] wr_data,
  output logic      [BYTE_W-1:0] q
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= EN_RESET;
    end else if (wr_stb) begin
      q <= wr_data & MASK;
    end
  end

endmodule : pfe_enable_reg

/* core/pfe_bank_top.sv */
/* pfe_bank_top: event flags, enable registers, request forwarding and
   an event interrupt, reached over AXI4-Lite.
   Assumes event strobes, core flags and global enables come from logic
   on aclk; strobes are one-cycle pulses. */
`timescale 1ns/10ps
module pfe_bank_top
  import pfe_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [AW-1:0]             s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [DW-1:0]             s_axi_wdata,
  input  wire logic [STRB_W-1:0]         s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic      [1:0]                s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [AW-1:0]             s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic      [DW-1:0]             s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [GATE_W-1:0]         gate_event,
  input  wire logic [CC_W-1:0]           capcomp_capture,
  input  wire logic [CC_W-1:0]           capcomp_compare,
  input  wire logic [CC_W*CC_MODE_W-1:0] capcomp_mode,
  input  wire logic                      scan_event,
  input  wire logic                      checksum_event,
  input  wire logic                      nonvolatile_event,
  input  wire logic                      waveform_event,
  input  wire logic [XEN_W-1:0]          other_flag_enables,
  input  wire logic [CORE_W-1:0]         core_flags,
  input  wire logic                      global_enable,
  input  wire logic                      peripheral_group_enable,
  output logic      [FL_W-1:0]           flags,
  output logic      [BYTE_W-1:0]         core_source_enables,
  output logic      [BYTE_W-1:0]         clock_adc_enables,
  output logic      [BYTE_W-1:0]         voltage_comparator_enables,
  output logic      [BYTE_W-1:0]         serial_port_enables,
  output logic      [BYTE_W-1:0]         timer_event_enables,
  output logic      [BYTE_W-1:0]         timer_gate_enables,
  output logic      [FL_W-1:0]           flag_req,
  output logic                           core_req,
  output logic                           periph_req,
  output logic                           irq
);

  // ****************************************
  // Declarations
  // ****************************************
  pfe_wstate_t         ws_reg;
  pfe_wstate_t         ws_next;
  pfe_rstate_t         rs_reg;
  logic                aw_have_reg;
  logic                aw_have_next;
  logic                w_have_reg;
  logic                w_have_next;
  logic [AW-1:0]       awaddr_reg;
  logic [DW-1:0]       wdata_reg;
  logic [STRB_W-1:0]   wstrb_reg;
  logic                awready_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [DW-1:0]       rdata_reg;
  logic [1:0]          rresp_reg;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic                do_write;
  logic                wr_lo;
  logic                wr_hi;
  logic [IW-1:0]       wr_idx;
  logic                wr_gate;
  logic                wr_cc;
  logic                wr_sys;
  logic [FL_W-1:0]     rd_val;
  logic [IW-1:0]       rd_idx;
  logic [BYTE_W-1:0]   en_q [NUM_EN];
  logic [FL_W-1:0]     mask_reg;
  logic [FL_W-1:0]     bank_en;
  logic [CORE_W-1:0]   core_sel;
  logic                irq_reg;
  logic                core_req_reg;
  logic                periph_req_reg;
  logic [FL_W-1:0]     flag_req_reg;

  pfe_sticky_if #(.W(FL_W)) flag_if ();
  pfe_sticky_if #(.W(FL_W)) stat_if ();

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign aw_take  = s_axi_awvalid && awready_reg;
  assign w_take   = s_axi_wvalid && wready_reg;
  assign do_write = ws_reg == WS_IDLE && aw_have_reg && w_have_reg;
  assign wr_idx   = addr_idx(awaddr_reg);
  assign wr_lo    = do_write && is_mapped(awaddr_reg) && wstrb_reg[0];
  assign wr_hi    = do_write && is_mapped(awaddr_reg) && wstrb_reg[1];
  assign wr_gate  = wr_lo && wr_idx == IDX_GATE_FLAGS;
  assign wr_cc    = wr_lo && wr_idx == IDX_CC_FLAGS;
  assign wr_sys   = wr_lo && wr_idx == IDX_SYS_FLAGS;

  always_comb begin
    ws_next      = ws_reg;
    aw_have_next = aw_have_reg || aw_take;
    w_have_next  = w_have_reg || w_take;
    case (ws_reg)
      WS_IDLE: begin
        if (do_write) begin
          ws_next      = WS_RESP;
          aw_have_next = 1'b0;
          w_have_next  = 1'b0;
        end
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          ws_next = WS_IDLE;
        end
      end
      default: ws_next = WS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_reg      <= WS_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      ws_reg      <= ws_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awready_reg <= !aw_have_next && ws_next == WS_IDLE;
      wready_reg  <= !w_have_next && ws_next == WS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (ws_reg == WS_RESP && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign ar_take = s_axi_arvalid && arready_reg;
  assign rd_idx  = addr_idx(s_axi_araddr);

  // Reserved bits read as zero
  always_comb begin
    rd_val = '0;
    case (rd_idx)
      IDX_GATE_FLAGS:
        rd_val = FL_W'(flag_if.q[FL_GATE_LSB +: GATE_W]);
      IDX_CC_FLAGS:
        rd_val = FL_W'(flag_if.q[FL_CC_LSB +: CC_W]);
      IDX_SYS_FLAGS: begin
        rd_val[SYS_SCAN_BIT] = flag_if.q[FL_SCAN];
        rd_val[SYS_CRC_BIT]  = flag_if.q[FL_CRC];
        rd_val[SYS_NVM_BIT]  = flag_if.q[FL_NVM];
        rd_val[SYS_WAVE_BIT] = flag_if.q[FL_WAVE];
      end
      IDX_IRQ_STATUS: rd_val = stat_if.q;
      IDX_IRQ_MASK:   rd_val = mask_reg;
      default: begin
        for (int i = 0; i < NUM_EN; i++) begin
          if (rd_idx == EN_IDX[i]) begin
            rd_val = FL_W'(en_q[i]);
          end
        end
      end
    endcase
    if (!is_mapped(s_axi_araddr)) begin
      rd_val = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_reg      <= RS_IDLE;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      case (rs_reg)
        RS_IDLE: begin
          arready_reg <= 1'b1;
          if (ar_take) begin
            rs_reg      <= RS_DATA;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= DW'(rd_val);
            rresp_reg   <= is_mapped(s_axi_araddr) ? RESP_OKAY
                                                   : RESP_SLVERR;
          end
        end
        RS_DATA: begin
          if (s_axi_rready) begin
            rs_reg      <= RS_IDLE;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
          end
        end
        default: rs_reg <= RS_IDLE;
      endcase
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  always_comb begin
    flag_if.set = '0;
    flag_if.set[FL_GATE_LSB +: GATE_W] = gate_event;
    for (int i = 0; i < CC_W; i++) begin
      flag_if.set[FL_CC_LSB + i] = cc_hit(
        capcomp_mode[i*CC_MODE_W +: CC_MODE_W],
        capcomp_capture[i], capcomp_compare[i]);
    end
    flag_if.set[FL_SCAN] = scan_event;
    flag_if.set[FL_CRC]  = checksum_event;
    flag_if.set[FL_NVM]  = nonvolatile_event;
    flag_if.set[FL_WAVE] = waveform_event;
  end

  // Software may write either value; zero clears the flag
  always_comb begin
    flag_if.wr_en  = '0;
    flag_if.wr_val = '0;
    if (wr_gate) begin
      flag_if.wr_en[FL_GATE_LSB +: GATE_W]  = '1;
      flag_if.wr_val[FL_GATE_LSB +: GATE_W] = wdata_reg[GATE_W-1:0];
    end
    if (wr_cc) begin
      flag_if.wr_en[FL_CC_LSB +: CC_W]  = '1;
      flag_if.wr_val[FL_CC_LSB +: CC_W] = wdata_reg[CC_W-1:0];
    end
    if (wr_sys) begin
      flag_if.wr_en[FL_SCAN]  = 1'b1;
      flag_if.wr_en[FL_CRC]   = 1'b1;
      flag_if.wr_en[FL_NVM]   = 1'b1;
      flag_if.wr_en[FL_WAVE]  = 1'b1;
      flag_if.wr_val[FL_SCAN] = wdata_reg[SYS_SCAN_BIT];
      flag_if.wr_val[FL_CRC]  = wdata_reg[SYS_CRC_BIT];
      flag_if.wr_val[FL_NVM]  = wdata_reg[SYS_NVM_BIT];
      flag_if.wr_val[FL_WAVE] = wdata_reg[SYS_WAVE_BIT];
    end
  end

  // Flags hold until written; reset clears them
  pfe_sticky_bank #(.W(FL_W), .W1C(1'b0)) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sb      (flag_if.bank)
  );

  // ****************************************
  // Enable registers
  // ****************************************
  for (genvar g = 0; g < NUM_EN; g++) begin : g_en
    pfe_enable_reg #(.MASK(EN_MASK[g])) u_en (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_stb  (wr_lo && wr_idx == EN_IDX[g]),
      .wr_data (wdata_reg[BYTE_W-1:0]),
      .q       (en_q[g])
    );
  end

  assign core_source_enables        = en_q[0];
  assign clock_adc_enables          = en_q[1];
  assign voltage_comparator_enables = en_q[2];
  assign serial_port_enables        = en_q[3];
  assign timer_event_enables        = en_q[4];
  assign timer_gate_enables         = en_q[5];

  // ****************************************
  // Request forwarding
  // ****************************************
  assign bank_en  = {other_flag_enables,
                     en_q[EN_GATE][GATE_W-1:0]};
  assign core_sel = {en_q[EN_CORE][TIMER0_EN_BIT],
                     en_q[EN_CORE][PINCHG_EN_BIT],
                     en_q[EN_CORE][EXT_EN_LSB +: EXT_W]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_req_reg   <= '0;
      core_req_reg   <= 1'b0;
      periph_req_reg <= 1'b0;
    end else begin
      flag_req_reg <= flag_if.q & bank_en;
      core_req_reg <= global_enable &&
                      (|(core_flags & core_sel));
      periph_req_reg <= global_enable && peripheral_group_enable &&
                        (|(flag_if.q & bank_en));
    end
  end

  // ****************************************
  // Event interrupt
  // ****************************************
  always_comb begin
    stat_if.set    = flag_if.set;
    stat_if.wr_val = wdata_reg[FL_W-1:0];
    stat_if.wr_en  = '0;
    if (wr_idx == IDX_IRQ_STATUS) begin
      stat_if.wr_en = {wr_hi, {BYTE_W{wr_lo}}};
    end
  end

  pfe_sticky_bank #(.W(FL_W), .W1C(1'b1)) u_status (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sb      (stat_if.bank)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= FL_RESET;
    end else if (wr_idx == IDX_IRQ_MASK) begin
      if (wr_lo) begin
        mask_reg[BYTE_W-1:0] <= wdata_reg[BYTE_W-1:0];
      end
      if (wr_hi) begin
        mask_reg[FL_W-1] <= wdata_reg[FL_W-1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_if.q & mask_reg);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign flags         = flag_if.q;
  assign flag_req      = flag_req_reg;
  assign core_req      = core_req_reg;
  assign periph_req    = periph_req_reg;
  assign irq           = irq_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_GATE_SET: assert property (
    gate_event[0] |=> flags[FL_GATE_LSB])
    else $error("gate event did not set its flag");
  AST_CC_CAPTURE: assert property (
    (capcomp_mode[CC_MODE_W-1:0] == CC_CAPTURE && capcomp_capture[0])
    |=> flags[FL_CC_LSB])
    else $error("capture did not set unit flag");
  AST_CC_PWM: assert property (
    (capcomp_mode[CC_MODE_W-1:0] == CC_PWM && !flags[FL_CC_LSB] &&
     !wr_cc) |=> !flags[FL_CC_LSB])
    else $error("unit flag set in pwm mode");
  AST_SCAN_SET: assert property (
    scan_event |=> flags[FL_SCAN])
    else $error("scan event lost");
  AST_CRC_SET: assert property (
    checksum_event |=> flags[FL_CRC])
    else $error("checksum event lost");
  AST_NVM_SET: assert property (
    nonvolatile_event |=> flags[FL_NVM])
    else $error("memory event lost");
  AST_WAVE_SET: assert property (
    waveform_event |=> flags[FL_WAVE])
    else $error("waveform event lost");
  AST_CLEAR_ZERO: assert property (
    (wr_gate && !wdata_reg[0] && !gate_event[0])
    |=> !flags[FL_GATE_LSB])
    else $error("writing zero did not clear gate flag");
  AST_FLAG_STABLE: assert property (
    (!wr_gate && !gate_event[0]) |=> $stable(flags[FL_GATE_LSB]))
    else $error("gate flag changed without cause");
  AST_SET_WINS: assert property (
    (wr_gate && !wdata_reg[1] && gate_event[1])
    |=> flags[FL_GATE_LSB+1])
    else $error("event lost against clear");
  AST_CORE_EN: assert property (
    (wr_lo && wr_idx == IDX_CORE_EN) |=> core_source_enables ==
    ($past(wdata_reg[BYTE_W-1:0]) & EN_MASK[EN_CORE]))
    else $error("core enable write not stored");
  AST_CORE_REQ: assert property (
    (global_enable && !peripheral_group_enable &&
     (|(core_flags & core_sel))) |=> core_req)
    else $error("core request blocked by group enable");
  AST_FLAG_REQ: assert property (
    ##1 flag_req == ($past(flags) & $past(bank_en)))
    else $error("request does not follow flag and enable");

endmodule : pfe_bank_top

/* dv/pfe_evt_src.sv */
/* pfe_evt_src: model of the peripheral event sources.
   Assumes requests on fire are driven on aclk. */
`timescale 1ns/10ps
module pfe_evt_src (
  input  wire logic       aclk,
  input  wire logic [8:0] fire,
  output logic      [8:0] ev
);
  // One-cycle strobe per request, low otherwise
  always_ff @(posedge aclk) begin
    ev <= fire;
  end
endmodule : pfe_evt_src

/* dv/test_peripheral_irq_flag_enable_bank.sv */
/* Self-checking bench of the flag and enable bank.
   Assumes pfe_pkg, the design and pfe_evt_src are compiled first. */
`timescale 1ns/10ps
module test_peripheral_irq_flag_enable_bank;
  import pfe_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, capcomp_mode = 4'h9;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, scan_event, checksum_event;
  logic nonvolatile_event, waveform_event, core_req, periph_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, capcomp_capture, capcomp_compare;
  logic [2:0] gate_event;
  logic [5:0] other_flag_enables = 6'h3f;
  logic [4:0] core_flags = 5'h1f;
  logic global_enable = 1, peripheral_group_enable = 0;
  logic [8:0] flags, flag_req, fire = 0, ev;
  logic [7:0] core_source_enables, clock_adc_enables, serial_port_enables;
  logic [7:0] voltage_comparator_enables, timer_event_enables;
  logic [7:0] timer_gate_enables;
  logic [33:0] q[$];
  logic [1:0] qb[$];
  logic [47:0] en_all;
  int n_mismatch = 0, n_tests = 0, seed = 50171;
  pfe_bank_top DUT (.*);
  pfe_evt_src SRC (.aclk(aclk), .fire(fire), .ev(ev));
  assign {waveform_event, nonvolatile_event, checksum_event, scan_event,
          capcomp_capture, gate_event} = ev;
  assign capcomp_compare = ev[4:3];
  assign en_all = {timer_gate_enables, timer_event_enables,
                   serial_port_enables, voltage_comparator_enables,
                   clock_adc_enables, core_source_enables};
  always #2.5 aclk = ~aclk;
  task chk(input string n, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [11:0] i, input logic [31:0] v,
          input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    qb.push_back(er);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin do @(negedge aclk); while (!s_axi_awready);
        @(posedge aclk); s_axi_awvalid <= 0; end
      begin do @(negedge aclk); while (!s_axi_wready);
        @(posedge aclk); s_axi_wvalid <= 0; end
    join
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [11:0] i, input logic [33:0] e);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    q.push_back(e);
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask : rd
  task pulse(input logic [8:0] f);
    @(posedge aclk);
    fire <= f;
    @(posedge aclk);
    fire <= 0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask : pulse
  always @(negedge aclk)
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
  always @(negedge aclk)
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", qb.pop_front(), s_axi_bresp);
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int k = 0; k < NUM_EN; k++) begin
      rd(EN_IDX[k], 34'h0);
      d = $random(seed);
      wr(EN_IDX[k], d);
      chk("enables", {26'h0, d[7:0] & EN_MASK[k]}, en_all[k*8 +: 8]);
      rd(EN_IDX[k], {26'h0, d[7:0] & EN_MASK[k]});
    end
    for (int k = 0; k < 3; k++)
      rd(12'(IDX_GATE_FLAGS + k), 34'h0);
    wr(IDX_IRQ_MASK, 32'h1ff);
    for (int k = 0; k < FL_W; k++) begin
      pulse(9'h1 << k);
      chk("flags", (34'h2 << k) - 34'h1, flags);
    end
    chk("flag_req", {6'h3f, d[2:0]}, flag_req);
    chk("periph_req", 0, periph_req);
    chk("irq", 1, irq);
    rd(IDX_GATE_FLAGS, 34'h07);
    rd(IDX_CC_FLAGS, 34'h03);
    rd(IDX_SYS_FLAGS, 34'he1);
    wr(IDX_CORE_EN, 32'h10);
    peripheral_group_enable <= 1;
    @(negedge aclk);
    chk("core_req", 1, core_req);
    wr(IDX_IRQ_STATUS, 32'h1ff);
    @(negedge aclk);
    chk("irq", 0, irq);
    chk("periph_req", 1, periph_req);
    wr(IDX_GATE_FLAGS, 0);
    wr(IDX_CC_FLAGS, 0);
    rd(IDX_GATE_FLAGS, 34'h0);
    // Gate event lands in the cycle the zero write is applied
    fork
      wr(IDX_GATE_FLAGS, 0);
      begin
        @(posedge aclk);
        fire <= 9'h002;
        @(posedge aclk);
        fire <= 0;
      end
    join
    rd(IDX_GATE_FLAGS, 34'h02);
    capcomp_mode <= 4'hf;
    pulse(9'h018);
    chk("pwm", 0, flags[4:3]);
    @(posedge aclk);
    global_enable <= 0;
    repeat (2) @(negedge aclk);
    chk("core_req", 0, core_req);
    chk("periph_req", 0, periph_req);
    rd(12'h000, {RESP_SLVERR, 32'h0});
    wr(12'h000, 32'h1ff, RESP_SLVERR);
    wrap_up();
  end
endmodule : test_peripheral_irq_flag_enable_bank
